// ===== rtl/sfm_exec.sv
// flag and move executor: apb slave issuing one instruction per command
// assumes a data memory that answers mem_req with a one-cycle ack pulse
// Contract
// - set carry op forces carry to one
// - clear carry op forces carry to zero
// - negative flag set and cleared by ops
// - zero flag cleared and set by ops
// - interrupt enable set and cleared by ops
// - sign flag set and cleared by ops
// - overflow flag set and cleared by ops
// - clear half carry forces it zero
// - transfer bit copied into chosen register bit
// - register pair copied whole in one step
// - post-increment load reads, then pointer plus one
// - pre-decrement load: pointer minus one, then read
`include "sfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sfm_exec (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data memory read port
  output sfm_pkg::sfm_mem_req_s mem_o,
  input wire sfm_pkg::sfm_mem_rsp_s mem_i
);
  import sfm_pkg::*;

  sfm_state_s st_ff;
  sfm_state_s nxt_st;
  logic acc;
  logic busy;
  logic hit_cmd;
  logic hit_stat;
  logic hit_rf;
  logic go;
  sfm_op_e op;
  logic [4:0] c_dst;
  logic [4:0] c_src;
  logic [2:0] c_bit;
  logic [4:0] c_ptr;
  logic [15:0] c_ptr_val;
  logic [15:0] cur_ptr_val;

  function automatic logic [15:0] pair(input logic [31:0][7:0] r,
                                       input logic [4:0] lo);
    pair = {r[lo + 5'h1], r[lo]};
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  assign acc = psel && penable;
  assign busy = (st_ff.fsm == SFM_LOAD);
  assign hit_cmd = (paddr == `SFM_CMD_OFF);
  assign hit_stat = (paddr == `SFM_STAT_OFF);
  assign hit_rf = (paddr >= `SFM_RF_BASE) && (paddr <= `SFM_RF_LAST) &&
                  (paddr[1:0] == 2'h0);
  // commands refused while a load waits, so its pointer cannot move under it
  assign go = ce && acc && pwrite && hit_cmd && !busy;
  assign op = sfm_op_e'(pwdata[`SFM_F_OP]);
  assign c_dst = pwdata[`SFM_F_DST];
  assign c_src = pwdata[`SFM_F_SRC];
  assign c_bit = pwdata[`SFM_F_BIT];
  assign c_ptr = `SFM_PTR_BASE + {2'h0, pwdata[`SFM_F_PTR], 1'b0};
  assign c_ptr_val = pair(st_ff.regs, c_ptr);
  assign cur_ptr_val = pair(st_ff.regs, st_ff.ptr_lo);
  // zero-wait slave; writes refused while a load is outstanding
  assign pready = 1'b1;
  always_comb begin
    pslverr = 1'b0;
    prdata = 32'h0;
    if (acc) begin
      if (!(hit_cmd || hit_stat || hit_rf)) begin
        pslverr = 1'b1;
      end else if (pwrite && busy) begin
        pslverr = 1'b1;
      end else if (hit_cmd) begin
        prdata = {31'h0, busy};
      end else if (hit_stat) begin
        prdata = {24'h0, st_ff.status_register};
      end else begin
        prdata = {24'h0, st_ff.regs[paddr[6:2]]};
      end
    end
  end
  assign mem_o = st_ff.mem;

  // ****************************************
  // execution
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.fsm)
      SFM_IDLE: begin
        if (go) begin
          case (op)
            SFM_SET_CARRY: nxt_st.status_register[`SFM_B_C] = 1'b1;
            SFM_CLR_CARRY: nxt_st.status_register[`SFM_B_C] = 1'b0;
            SFM_SET_NEG: nxt_st.status_register[`SFM_B_N] = 1'b1;
            SFM_CLR_NEG: nxt_st.status_register[`SFM_B_N] = 1'b0;
            SFM_SET_ZERO: nxt_st.status_register[`SFM_B_Z] = 1'b1;
            SFM_CLR_ZERO: nxt_st.status_register[`SFM_B_Z] = 1'b0;
            SFM_SET_INT: nxt_st.status_register[`SFM_B_I] = 1'b1;
            SFM_CLR_INT: nxt_st.status_register[`SFM_B_I] = 1'b0;
            SFM_SET_SIGN: nxt_st.status_register[`SFM_B_S] = 1'b1;
            SFM_CLR_SIGN: nxt_st.status_register[`SFM_B_S] = 1'b0;
            SFM_SET_OVF: nxt_st.status_register[`SFM_B_V] = 1'b1;
            SFM_CLR_OVF: nxt_st.status_register[`SFM_B_V] = 1'b0;
            SFM_CLR_HALF: nxt_st.status_register[`SFM_B_H] = 1'b0;
            SFM_BIT_LOAD: begin
              nxt_st.regs[c_dst][c_bit] = st_ff.status_register[`SFM_B_T];
            end
            SFM_COPY_PAIR: begin
              // pairs are even-aligned; low index bit ignored
              nxt_st.regs[{c_dst[4:1], 1'b0}] =
                st_ff.regs[{c_src[4:1], 1'b0}];
              nxt_st.regs[{c_dst[4:1], 1'b1}] =
                st_ff.regs[{c_src[4:1], 1'b1}];
            end
            SFM_LD_POST: begin
              nxt_st.fsm = SFM_LOAD;
              nxt_st.mem.req = 1'b1;
              nxt_st.mem.addr = c_ptr_val;
              nxt_st.post_inc = 1'b1;
              nxt_st.dst = c_dst;
              nxt_st.ptr_lo = c_ptr;
            end
            SFM_LD_PRE: begin
              // pointer lowered on the same edge the read goes out
              nxt_st.fsm = SFM_LOAD;
              nxt_st.mem.req = 1'b1;
              nxt_st.mem.addr = c_ptr_val - 16'h1;
              nxt_st.post_inc = 1'b0;
              nxt_st.dst = c_dst;
              nxt_st.ptr_lo = c_ptr;
              nxt_st.regs[c_ptr] = c_ptr_val[7:0] - 8'h1;
              nxt_st.regs[c_ptr + 5'h1] = nxt_st.mem.addr[15:8];
            end
            default: nxt_st = st_ff;
          endcase
        end else if (ce && acc && pwrite && hit_stat) begin
          nxt_st.status_register = pwdata[7:0];
        end else if (ce && acc && pwrite && hit_rf) begin
          nxt_st.regs[paddr[6:2]] = pwdata[7:0];
        end
      end
      SFM_LOAD: begin
        if (ce && mem_i.ack) begin
          nxt_st.fsm = SFM_IDLE;
          nxt_st.mem.req = 1'b0;
          nxt_st.regs[st_ff.dst] = mem_i.rdata;
          if (st_ff.post_inc) begin
            // pointer bump wins over a destination inside the pointer
            {nxt_st.regs[st_ff.ptr_lo + 5'h1], nxt_st.regs[st_ff.ptr_lo]} =
              st_ff.mem.addr + 16'h1;
          end
        end
      end
      default: nxt_st.fsm = SFM_IDLE;
    endcase
  end

  // ce low holds every flop, a pending load included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{fsm: SFM_IDLE, status_register: `SFM_STATUS_REGISTER_RST, regs: '0, dst: 5'h0,
                 ptr_lo: 5'h0, post_inc: 1'b0, mem: '0};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_issue_post;
    go && op == SFM_LD_POST ##1 st_ff.mem.req;
  endsequence
  sequence s_ack;
    ce && st_ff.fsm == SFM_LOAD && mem_i.ack;
  endsequence

  a_carry_set: assert property (go && op == SFM_SET_CARRY |=>
    st_ff.status_register[`SFM_B_C]) else $error("carry not set");
  a_carry_clr: assert property (go && op == SFM_CLR_CARRY |=>
    !st_ff.status_register[`SFM_B_C]) else $error("carry not cleared");
  a_neg_flag: assert property (go && (op == SFM_SET_NEG ||
    op == SFM_CLR_NEG) |=> st_ff.status_register[`SFM_B_N] == $past(op == SFM_SET_NEG))
    else $error("negative flag wrong");
  a_zero_flag: assert property (go && (op == SFM_SET_ZERO ||
    op == SFM_CLR_ZERO) |=> st_ff.status_register[`SFM_B_Z] == $past(op == SFM_SET_ZERO))
    else $error("zero flag wrong");
  a_int_flag: assert property (go && (op == SFM_SET_INT ||
    op == SFM_CLR_INT) |=> st_ff.status_register[`SFM_B_I] == $past(op == SFM_SET_INT))
    else $error("interrupt enable wrong");
  a_sign_flag: assert property (go && (op == SFM_SET_SIGN ||
    op == SFM_CLR_SIGN) |=> st_ff.status_register[`SFM_B_S] == $past(op == SFM_SET_SIGN))
    else $error("sign flag wrong");
  a_ovf_flag: assert property (go && (op == SFM_SET_OVF ||
    op == SFM_CLR_OVF) |=> st_ff.status_register[`SFM_B_V] == $past(op == SFM_SET_OVF))
    else $error("overflow flag wrong");
  a_half_clr: assert property (go && op == SFM_CLR_HALF |=>
    !st_ff.status_register[`SFM_B_H]) else $error("half carry not cleared");
  a_bit_load: assert property (go && op == SFM_BIT_LOAD |=>
    st_ff.regs[$past(c_dst)][$past(c_bit)] == $past(st_ff.status_register[`SFM_B_T]))
    else $error("transfer bit not loaded");
  a_pair_copy: assert property (go && op == SFM_COPY_PAIR |=>
    pair(st_ff.regs, {$past(c_dst[4:1]), 1'b0}) ==
    $past(pair(st_ff.regs, {c_src[4:1], 1'b0})))
    else $error("pair not copied");
  a_post_addr: assert property (s_issue_post |->
    st_ff.mem.addr == $past(c_ptr_val) && cur_ptr_val == $past(c_ptr_val))
    else $error("post-increment address wrong");
  a_post_bump: assert property (s_ack and st_ff.post_inc |=>
    cur_ptr_val == $past(st_ff.mem.addr) + 16'h1 && !st_ff.mem.req)
    else $error("pointer not incremented");
  a_pre_dec: assert property (go && op == SFM_LD_PRE |=>
    st_ff.mem.req && st_ff.mem.addr == $past(c_ptr_val) - 16'h1 &&
    cur_ptr_val == st_ff.mem.addr) else $error("pre-decrement wrong");
  a_flag_only: assert property (go && op >= SFM_SET_CARRY &&
    op <= SFM_CLR_HALF |=> st_ff.regs == $past(st_ff.regs) &&
    $countones(st_ff.status_register ^ $past(st_ff.status_register)) <= 1)
    else $error("flag op touched other state");
  a_nop_quiet: assert property (go && op == SFM_NOP |=>
    st_ff == $past(st_ff)) else $error("nop changed state");
  a_bit_others: assert property (go && op == SFM_BIT_LOAD |=>
    ((st_ff.regs[$past(c_dst)] ^ $past(st_ff.regs[c_dst])) &
    ~(8'h1 << $past(c_bit))) == 8'h0) else $error("bit load spilled");
  a_bit_status_register: assert property (go && op == SFM_BIT_LOAD |=>
    $stable(st_ff.status_register)) else $error("bit load touched status");
  a_pair_status_register: assert property (go && op == SFM_COPY_PAIR |=>
    $stable(st_ff.status_register)) else $error("pair copy touched status");

  // ****************************************
  // load port checks
  // ****************************************
  sequence s_issue_pre;
    go && op == SFM_LD_PRE ##1 st_ff.mem.req;
  endsequence
  sequence s_wait;
    st_ff.mem.req && !(ce && mem_i.ack);
  endsequence

  a_pre_issue: assert property (s_issue_pre |-> busy &&
    st_ff.ptr_lo == $past(c_ptr) && st_ff.dst == $past(c_dst))
    else $error("pre-decrement issue wrong");
  a_load_start: assert property (go && (op == SFM_LD_POST ||
    op == SFM_LD_PRE) |=> busy && st_ff.mem.req)
    else $error("load not started");
  a_req_hold: assert property (s_wait |=> st_ff.mem.req &&
    $stable(st_ff.mem.addr)) else $error("load request not held");
  a_req_drop: assert property (s_ack |=> !st_ff.mem.req && !busy)
    else $error("load request not dropped");
  a_load_data: assert property (s_ack and (!st_ff.post_inc ||
    (st_ff.dst != st_ff.ptr_lo && st_ff.dst != st_ff.ptr_lo + 5'h1)) |=>
    st_ff.regs[$past(st_ff.dst)] == $past(mem_i.rdata))
    else $error("load data not written");
  a_idle_quiet: assert property (!busy |-> !st_ff.mem.req)
    else $error("request outside a load");
  a_pre_hold: assert property (s_wait and !st_ff.post_inc |=>
    $stable(cur_ptr_val)) else $error("pointer moved during load");

  // ****************************************
  // register bus checks
  // ****************************************
  // writes during a load must raise pslverr; unmapped writes and frozen cycles must leave every flop alone
  a_busy_refuse: assert property (acc && pwrite && busy |-> pslverr)
    else $error("write during load not refused");
  a_stat_write: assert property (ce && acc && pwrite && hit_stat &&
    !busy |=> st_ff.status_register == $past(pwdata[7:0]))
    else $error("status write lost");
  a_rf_write: assert property (ce && acc && pwrite && hit_rf && !busy |=>
    st_ff.regs[$past(paddr[6:2])] == $past(pwdata[7:0]))
    else $error("register write lost");
  a_bad_quiet: assert property (ce && acc && pwrite && !busy &&
    !(hit_cmd || hit_stat || hit_rf) |=> st_ff == $past(st_ff))
    else $error("unmapped write changed state");
  a_ce_freeze: assert property (!ce |=> st_ff == $past(st_ff))
    else $error("state moved with enable low");
  a_bus_idle: assert property (!acc |-> prdata == 32'h0 && !pslverr)
    else $error("bus output outside access");
  a_bad_err: assert property (acc && !(hit_cmd || hit_stat || hit_rf) |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
endmodule
`default_nettype wire

// ===== rtl/sfm_params.svh
// offsets, field positions, reset values of the flag and move executor
// assumes a 12-bit apb byte address
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define SFM_CMD_OFF 12'h000
`define SFM_STAT_OFF 12'h004
`define SFM_RF_BASE 12'h100
`define SFM_RF_LAST 12'h17c
// ****************************************
// command word fields
// ****************************************
`define SFM_F_OP 4:0
`define SFM_F_DST 12:8
`define SFM_F_SRC 20:16
`define SFM_F_BIT 26:24
`define SFM_F_PTR 29:28
// ****************************************
// status register bits and reset, pointer base
// ****************************************
`define SFM_B_C 0
`define SFM_B_Z 1
`define SFM_B_N 2
`define SFM_B_V 3
`define SFM_B_S 4
`define SFM_B_H 5
`define SFM_B_T 6
`define SFM_B_I 7
`define SFM_STATUS_REGISTER_RST 8'h00
`define SFM_PTR_BASE 5'h1a
`endif

// ===== rtl/sfm_pkg.sv
// types of the flag and move executor
// assumes sfm_params.svh for numbers
package sfm_pkg;
  typedef enum logic [4:0] {
    SFM_NOP, SFM_SET_CARRY, SFM_CLR_CARRY, SFM_SET_NEG, SFM_CLR_NEG,
    SFM_SET_ZERO, SFM_CLR_ZERO, SFM_SET_INT, SFM_CLR_INT, SFM_SET_SIGN,
    SFM_CLR_SIGN, SFM_SET_OVF, SFM_CLR_OVF, SFM_CLR_HALF, SFM_BIT_LOAD,
    SFM_COPY_PAIR, SFM_LD_POST, SFM_LD_PRE
  } sfm_op_e;
  typedef enum logic [0:0] {SFM_IDLE, SFM_LOAD} sfm_fsm_e;
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } sfm_mem_req_s;
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } sfm_mem_rsp_s;
  typedef struct packed {
    sfm_fsm_e fsm;
    logic [7:0] status_register;
    logic [31:0][7:0] regs;
    logic [4:0] dst;
    logic [4:0] ptr_lo;
    logic post_inc;
    sfm_mem_req_s mem;
  } sfm_state_s;
endpackage

// ===== bench/sfm_mem_model.sv
// data memory model for the flag and move executor bench
// assumes one outstanding read and a one-cycle ack pulse
`timescale 1ns/1ps
`default_nettype none
module sfm_mem_model
  import sfm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // read port
  input wire sfm_mem_req_s mem_o,
  output sfm_mem_rsp_s mem_i
);
  int lat;
  logic [7:0] d;
  initial begin
    mem_i = '0;
    lat = 0;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && mem_o.req === 1'b1) begin
        // latency walks 0..3 so prompt and slow answers both occur
        repeat (lat) @(posedge pclk);
        lat = (lat + 1) % 4;
        d = mem_o.addr[7:0] ^ mem_o.addr[15:8] ^ 8'ha5;
        mem_i <= '{ack: 1'b1, rdata: d};
        @(posedge pclk);
        // data no longer held: show the inverse, not a stale copy
        mem_i <= '{ack: 1'b0, rdata: ~d};
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_status_flag_and_move_exec.sv
// self-checking bench of the flag and move executor
// assumes sfm_exec and the memory model sfm_mem_model
`include "sfm_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_status_flag_and_move_exec;
  import sfm_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sfm_mem_req_s mem_o;
  sfm_mem_rsp_s mem_i;
  int num_errors = 0, tests_run = 0, seed = 45565, k, b, s, n, lo;
  logic [7:0] m_status_register, m_regs[32];
  logic [15:0] p, a;
  int fb[13] = '{`SFM_B_C, `SFM_B_C, `SFM_B_N, `SFM_B_N, `SFM_B_Z,
    `SFM_B_Z, `SFM_B_I, `SFM_B_I, `SFM_B_S, `SFM_B_S, `SFM_B_V,
    `SFM_B_V, `SFM_B_H};
  sfm_exec i_sfm_exec (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_o(mem_o), .mem_i(mem_i));
  sfm_mem_model i_sfm_mem_model (.pclk(pclk), .presetn(presetn),
    .mem_o(mem_o), .mem_i(mem_i));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // apb master
  // ****************************************
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      num_errors++;
      results;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wreg(input int r, input logic [7:0] d);
    apb(1'b1, `SFM_RF_BASE + 12'(4 * r), {24'h0, d});
    m_regs[r] = d;
  endtask
  task creg(input int r);
    apb(1'b0, `SFM_RF_BASE + 12'(4 * r), 32'h0);
    `CHK(rd[7:0], m_regs[r])
  endtask
  task wst(input logic [7:0] d);
    apb(1'b1, `SFM_STAT_OFF, {24'h0, d});
    m_status_register = d;
  endtask
  // polls busy under a bound; loads may take several cycles
  task cmd(input logic [31:0] c);
    apb(1'b1, `SFM_CMD_OFF, c);
    n = 0;
    do begin
      apb(1'b0, `SFM_CMD_OFF, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results;
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    m_status_register = 8'h00;
    for (k = 0; k < 32; k++) m_regs[k] = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 32; k++) creg(k);
    $display("reset values done");
    for (k = 0; k < 13; k++) begin
      wst(8'($random(seed)));
      wreg(k, 8'($random(seed)));
      cmd(32'(k + 1));
      m_status_register[fb[k]] = (k % 2 == 0 && k < 12);
      apb(1'b0, `SFM_STAT_OFF, 32'h0);
      `CHK(rd[7:0], m_status_register)
      `CHK(rd[fb[k]], m_status_register[fb[k]])
      creg(k);
    end
    $display("flag ops done");
    for (k = 0; k < 8; k++) begin
      b = {$random(seed)} % 32;
      wst(8'($random(seed)));
      wreg(b, 8'($random(seed)));
      cmd({5'h0, 3'(k), 11'h0, 5'(b), 3'h0, 5'd14});
      m_regs[b][k] = m_status_register[`SFM_B_T];
      creg(b);
    end
    $display("bit load done");
    for (k = 0; k < 4; k++) begin
      b = 2 * ({$random(seed)} % 16);
      s = 2 * ({$random(seed)} % 16);
      wreg(s, 8'($random(seed)));
      wreg(s + 1, 8'($random(seed)));
      wreg(b + 1, 8'($random(seed)));
      cmd({11'h0, 5'(s), 3'h0, 5'(b), 3'h0, 5'd15});
      m_regs[b] = m_regs[s];
      m_regs[b + 1] = m_regs[s + 1];
      creg(b);
      creg(b + 1);
    end
    $display("pair copy done");
    for (k = 0; k < 6; k++) begin
      lo = 26 + 2 * (k % 3);
      p = 16'($random(seed));
      b = {$random(seed)} % 26;
      wreg(lo, p[7:0]);
      wreg(lo + 1, p[15:8]);
      cmd({2'h0, 2'(k % 3), 15'h0, 5'(b), 3'h0, k < 3 ? 5'd16 : 5'd17});
      a = k < 3 ? p : p - 16'd1;
      m_regs[b] = a[7:0] ^ a[15:8] ^ 8'ha5;
      p = k < 3 ? p + 16'd1 : a;
      m_regs[lo] = p[7:0];
      m_regs[lo + 1] = p[15:8];
      creg(b);
      creg(lo);
      creg(lo + 1);
    end
    $display("pointer loads done");
    apb(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("unmapped access done");
    wst(8'h00);
    ce <= 1'b0;
    apb(1'b1, `SFM_CMD_OFF, 32'h1);
    `CHK(err, 1'b0)
    ce <= 1'b1;
    apb(1'b0, `SFM_STAT_OFF, 32'h0);
    `CHK({err, rd[7:0]}, {1'b0, m_status_register})
    $display("clock enable done");
    results;
  end
endmodule
`default_nettype wire
